// File: inc/pmc_pkg.sv
// power-mode control constants and carrier types
// assumes one core clock domain and a plain register port from the core
package pmc_pkg;

  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned NUM_DAC    = 2;
  localparam int unsigned PORT_W     = 32;
  localparam int unsigned IRQ_W      = 8;

  localparam logic [ADDR_W-1:0] MODE_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] CONV_OFS   = 4'h1;
  localparam logic [ADDR_W-1:0] IRQEN_OFS  = 4'h2;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 4'h3;

  // mode register: bit 0 requests idle, bit 1 requests powerdown
  localparam int unsigned MODE_IDLE_BIT = 0;
  localparam int unsigned MODE_PD_BIT   = 1;
  // converter register: bit 0 adc, bits 1.. dacs
  localparam int unsigned CONV_ADC_BIT  = 0;
  localparam int unsigned CONV_DAC_LSB  = 1;
  // status register: bits 1:0 mode, bit 2 reference on
  localparam int unsigned STAT_REF_BIT  = 2;

  localparam logic [DATA_W-1:0] CONV_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IRQEN_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;

  typedef enum logic [1:0] {
    PMC_NORMAL = 2'b00,
    PMC_IDLE   = 2'b01,
    PMC_PDOWN  = 2'b11
  } pmc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pmc_req_t;

  typedef struct packed {
    logic [PORT_W-1:0]  port;
    logic [NUM_DAC-1:0] dac;
  } pmc_pins_t;

endpackage

// File: rtl/pmc_power_ctrl.sv
// power-mode control: mode state, clock gates, pin freeze, converter enables
// assumes rst_n comes from an external power-on reset, already synchronous-safe
`timescale 1ns/10ps
module pmc_power_ctrl
  import pmc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire pmc_req_t             regReq,
  output logic      [DATA_W-1:0]    regRdata,
  input  wire logic [IRQ_W-1:0]     irqReq,
  input  wire pmc_pins_t            pinsIn,
  output pmc_pins_t                 pinsOut,
  output logic      [NUM_DAC-1:0]   dacOe_n,
  output logic                      coreClkEn,
  output logic                      periphClkEn,
  output logic                      oscEn,
  output logic                      adcEn,
  output logic      [NUM_DAC-1:0]   dacEn,
  output logic                      refEn
);

  pmc_mode_t                mode;
  logic      [DATA_W-1:0]   convReg;
  logic      [IRQ_W-1:0]    irqEn;
  logic      [IRQ_W-1:0]    irqSync1;
  logic      [IRQ_W-1:0]    irqSync2;
  logic                     wakeIrq;

  function automatic logic hit(input pmc_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.addr == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // interrupt inputs come from other logic; synchronise them anyway
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSync1 <= '0;
      irqSync2 <= '0;
    end else begin
      irqSync1 <= irqReq;
      irqSync2 <= irqSync1;
    end
  end

  assign wakeIrq = |(irqSync2 & irqEn);

  ////////////////////////////////////////////////////////////////////////////
  // mode state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PMC_NORMAL;
    end else begin
      case (mode)
        PMC_NORMAL: begin
          if (regReq.wr && hit(regReq, MODE_OFS)) begin
            if (regReq.wdata[MODE_PD_BIT]) begin
              mode <= PMC_PDOWN;
            end else if (regReq.wdata[MODE_IDLE_BIT]) begin
              mode <= PMC_IDLE;
            end
          end
        end
        PMC_IDLE: begin
          if (wakeIrq) begin
            mode <= PMC_NORMAL;
          end
        end
        default: mode <= mode;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      convReg <= CONV_RST;
      irqEn   <= IRQEN_RST;
    end else if (regReq.wr && mode == PMC_NORMAL) begin
      if (hit(regReq, CONV_OFS)) begin
        convReg <= regReq.wdata;
      end else if (hit(regReq, IRQEN_OFS)) begin
        irqEn <= regReq.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= ZERO_DATA;
    end else if (regReq.rd) begin
      if (hit(regReq, MODE_OFS)) begin
        regRdata <= {{(DATA_W-2){1'b0}}, mode};
      end else if (hit(regReq, CONV_OFS)) begin
        regRdata <= convReg;
      end else if (hit(regReq, IRQEN_OFS)) begin
        regRdata <= irqEn;
      end else if (hit(regReq, STAT_OFS)) begin
        regRdata <= {{(DATA_W-3){1'b0}}, refEn, mode};
      end else begin
        regRdata <= ZERO_DATA;
      end
    end else begin
      regRdata <= ZERO_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gates, registered so the gating cells see a clean level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreClkEn   <= 1'b1;
      periphClkEn <= 1'b1;
      oscEn       <= 1'b1;
    end else begin
      coreClkEn   <= (mode == PMC_NORMAL);
      periphClkEn <= (mode != PMC_PDOWN);
      oscEn       <= (mode != PMC_PDOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog enables; everything analog is off in powerdown
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adcEn <= 1'b0;
      dacEn <= '0;
      refEn <= 1'b0;
    end else begin
      // each converter from its own bit
      adcEn <= convReg[CONV_ADC_BIT] && mode != PMC_PDOWN;
      dacEn <= convReg[CONV_DAC_LSB +: NUM_DAC] & {NUM_DAC{mode != PMC_PDOWN}};
      refEn <= (convReg[CONV_ADC_BIT] || |convReg[CONV_DAC_LSB +: NUM_DAC])
               && mode != PMC_PDOWN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinsOut <= '0;
      dacOe_n <= '0;
    end else begin
      if (mode == PMC_NORMAL) begin
        pinsOut <= pinsIn;
      end
      dacOe_n <= {NUM_DAC{mode == PMC_PDOWN}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence pdReq_s;
    mode == PMC_NORMAL && regReq.wr && hit(regReq, MODE_OFS) && regReq.wdata[MODE_PD_BIT];
  endsequence

  sequence pdGates_s;
    !oscEn && !periphClkEn && !coreClkEn;
  endsequence

  pd_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pdReq_s |=> ##1 pdGates_s) else $error("powerdown did not stop clocks");

  pd_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_PDOWN |=> mode == PMC_PDOWN) else $error("powerdown left without reset");

  idle_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_NORMAL && regReq.wr && hit(regReq, MODE_OFS) && !regReq.wdata[MODE_PD_BIT]
    && regReq.wdata[MODE_IDLE_BIT] |=> mode == PMC_IDLE) else $error("idle not entered");

  idle_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_IDLE |=> !coreClkEn && periphClkEn && oscEn) else $error("idle gating wrong");

  idle_periph_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == PMC_IDLE |-> periphClkEn) else $error("peripheral clock lost in idle");

  pin_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != PMC_NORMAL |=> $stable(pinsOut)) else $error("pins changed while frozen");

  idle_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_IDLE && wakeIrq |=> mode == PMC_NORMAL ##1 coreClkEn)
    else $error("idle not left on interrupt");

  dac_tri_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_PDOWN |=> dacOe_n == {NUM_DAC{1'b1}}) else $error("dac not tristated");

  conv_en_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != PMC_PDOWN |=> adcEn == $past(convReg[CONV_ADC_BIT])) else $error("adc enable wrong");

  ref_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (adcEn || |dacEn) |-> refEn) else $error("reference off with converter on");

  normal_clk_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_NORMAL |=> coreClkEn) else $error("core clock off in normal");

  ////////////////////////////////////////////////////////////////////////////
  // check helper: cycles spent outside normal mode, saturating
  logic [DATA_W-1:0] lowCnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= '0;
    end else if (mode == PMC_NORMAL) begin
      lowCnt <= '0;
    end else if (lowCnt != '1) begin
      lowCnt <= lowCnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // further checks: mode exits, converter enables, read data
  sequence idleReq_s;
    mode == PMC_NORMAL && regReq.wr && hit(regReq, MODE_OFS)
    && !regReq.wdata[MODE_PD_BIT] && regReq.wdata[MODE_IDLE_BIT];
  endsequence

  sequence idleGates_s;
    !coreClkEn && periphClkEn && oscEn;
  endsequence

  sequence quietIdle_s;
    mode == PMC_IDLE && !wakeIrq;
  endsequence

  sequence wakeHit_s;
    mode == PMC_IDLE && |(irqReq & irqEn);
  endsequence

  sequence analogOff_s;
    !adcEn && dacEn == '0 && !refEn;
  endsequence

  idle_gates_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    idleReq_s |=> ##1 idleGates_s)
    else $error("idle did not gate the core clock");

  core_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    lowCnt != '0 |-> !coreClkEn)
    else $error("core clock running in low power");

  low_periph_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    lowCnt != '0 && mode == PMC_IDLE |-> periphClkEn)
    else $error("peripheral clock stopped in idle");

  idle_stay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    quietIdle_s |=> mode == PMC_IDLE)
    else $error("idle left without interrupt");

  wake_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wakeHit_s |-> ##[1:4] mode == PMC_NORMAL)
    else $error("enabled interrupt did not wake idle");

  pd_analog_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_PDOWN |=> analogOff_s)
    else $error("analog left on in powerdown");

  pd_pins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_PDOWN |=> $stable(pinsOut))
    else $error("port pins moved in powerdown");

  pd_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_PDOWN && wakeIrq |=> mode == PMC_PDOWN ##1 !oscEn)
    else $error("interrupt woke powerdown");

  dac_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != PMC_PDOWN |=> dacOe_n == '0)
    else $error("dac released outside powerdown");

  pins_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == PMC_NORMAL |=> pinsOut == $past(pinsIn))
    else $error("pins not following core");

  dac_en_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode != PMC_PDOWN |=> dacEn == $past(convReg[CONV_DAC_LSB +: NUM_DAC]))
    else $error("dac enable wrong");

  ref_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    refEn |-> adcEn || dacEn != '0)
    else $error("reference on with converters off");

  rd_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !regReq.rd |=> regRdata == ZERO_DATA)
    else $error("read data not cleared");

  conv_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    regReq.rd && hit(regReq, CONV_OFS) |=> regRdata == $past(convReg))
    else $error("converter read wrong");

  stat_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    regReq.rd && hit(regReq, STAT_OFS) |=> regRdata[STAT_REF_BIT] == $past(refEn)
    && regRdata[$bits(pmc_mode_t)-1:0] == $past(mode))
    else $error("status read wrong");

endmodule // pmc_power_ctrl

// File: test/pmc_por_model.sv
// behavioural external power-on reset source, active-high output
// assumes the bench drives supplyOk and inverts resetHi onto rst_n
`timescale 1ns/10ps
module pmc_por_model #(
  parameter int HOLD_CYC = 3
) (
  input  wire logic core_clk,
  input  wire logic supplyOk,
  output logic      resetHi
);
  int holdCnt;
  always_ff @(posedge core_clk or negedge supplyOk) begin
    if (!supplyOk) begin
      holdCnt <= 0;
      resetHi <= 1'b1;
    end else if (holdCnt < HOLD_CYC) begin
      holdCnt <= holdCnt + 1;
      resetHi <= 1'b1;
    end else begin
      resetHi <= 1'b0;
    end
  end
endmodule // pmc_por_model

// File: test/power_mode_control_test.sv
// self-checking bench for the power-mode controller
// assumes the external reset comes from pmc_por_model, inverted here
`timescale 1ns/10ps
module power_mode_control_test;
  import pmc_pkg::*;
  typedef struct {logic [7:0] w; logic [3:0] e;} pmc_row_t;
  logic core_clk = 1'b0, supplyOk = 1'b0, resetHi;
  wire logic rst_n = ~resetHi;
  pmc_req_t regReq = '0;
  logic [DATA_W-1:0] regRdata, rd;
  logic [IRQ_W-1:0] irqReq = '0;
  pmc_pins_t pinsIn = '0, pinsOut;
  logic [NUM_DAC-1:0] dacOe_n, dacEn;
  logic coreClkEn, periphClkEn, oscEn, adcEn, refEn;
  int miscompares = 0, n_checks = 0;
  pmc_row_t rows[7] = '{'{8'h00, 4'h0}, '{8'h01, 4'h9}, '{8'h02, 4'ha}, '{8'h04, 4'hc},
                        '{8'h06, 4'he}, '{8'h07, 4'hf}, '{8'h00, 4'h0}};
  always #10 core_clk = ~core_clk;
  pmc_por_model #(.HOLD_CYC(3)) por_u (.core_clk(core_clk), .supplyOk(supplyOk),
    .resetHi(resetHi));
  pmc_power_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .irqReq(irqReq), .pinsIn(pinsIn), .pinsOut(pinsOut),
    .dacOe_n(dacOe_n), .coreClkEn(coreClkEn), .periphClkEn(periphClkEn), .oscEn(oscEn),
    .adcEn(adcEn), .dacEn(dacEn), .refEn(refEn));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= {a, d, 2'b10};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a);
    @(posedge core_clk);
    regReq <= {a, 8'h00, 2'b01};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    test_done;
  end
  initial begin
    cyc(1);
    supplyOk <= 1'b1;
    cyc(6);
    chk({coreClkEn, periphClkEn, oscEn, refEn}, 4'he);
    foreach (rows[i]) begin
      wr(CONV_OFS, rows[i].w);
      cyc(2);
      chk({refEn, dacEn, adcEn}, rows[i].e);
    end
    wr(CONV_OFS, 8'h02);
    rdreg(STAT_OFS);
    chk(rd, 8'h04);
    rdreg(4'hf);
    chk(rd, 8'h00);
    pinsIn <= {32'ha5c3_0f11, 2'b10};
    wr(IRQEN_OFS, 8'h04);
    wr(MODE_OFS, 8'h01);
    cyc(2);
    chk({coreClkEn, periphClkEn, oscEn, dacOe_n}, 5'b01100);
    pinsIn <= {32'h5a3c_f0ee, 2'b01};
    irqReq <= 8'h01;
    cyc(8);
    chk({coreClkEn, pinsOut}, {1'b0, 32'ha5c3_0f11, 2'b10});
    irqReq <= 8'h04;
    for (int i = 0; i < 12 && coreClkEn !== 1'b1; i++) cyc(1);
    chk(coreClkEn, 1'b1);
    irqReq <= 8'h00;
    rdreg(MODE_OFS);
    chk(rd, 8'h00);
    wr(CONV_OFS, 8'h07);
    pinsIn <= {32'h1234_5678, 2'b11};
    wr(MODE_OFS, 8'h02);
    cyc(2);
    chk({coreClkEn, periphClkEn, oscEn, dacOe_n}, 5'b00011);
    pinsIn <= '0;
    irqReq <= 8'h04;
    cyc(8);
    chk({oscEn, refEn, pinsOut}, {2'b00, 32'h1234_5678, 2'b11});
    supplyOk <= 1'b0;
    irqReq <= 8'h00;
    cyc(2);
    supplyOk <= 1'b1;
    for (int i = 0; i < 12 && rst_n !== 1'b1; i++) cyc(1);
    cyc(1);
    chk({coreClkEn, periphClkEn, oscEn, adcEn, dacOe_n}, 6'b111000);
    test_done;
  end
endmodule // power_mode_control_test
